// ---- hdl/pamr_pkg.sv ----
// Shared constants and types for the PHY mode register bank
package pamr_pkg;
  // Register indices on the management port
  localparam int unsigned IDX_W        = 5;
  localparam int unsigned REG_W        = 16;
  localparam logic [4:0]  IDX_AN_EXP   = 5'h06;
  localparam logic [4:0]  IDX_MODE_CS  = 5'h11;
  localparam logic [4:0]  IDX_SPC_MODE = 5'h12;
  // Field positions
  localparam int unsigned EXP_PDF_BIT  = 4;
  localparam int unsigned EXP_LPNP_BIT = 3;
  localparam int unsigned EXP_LCNP_BIT = 2;
  localparam int unsigned EXP_PGRX_BIT = 1;
  localparam int unsigned EXP_LPAN_BIT = 0;
  localparam int unsigned MCS_EDPD_BIT = 13;
  localparam int unsigned MCS_NRG_BIT  = 1;
  localparam int unsigned MCS_RSV_BIT  = 0;
  localparam int unsigned SM_MODE_LSB  = 5;
  localparam int unsigned SM_MODE_MSB  = 7;
  localparam int unsigned SM_ADDR_MSB  = 4;
  // Reset values
  localparam logic       EDPD_RST      = 1'b0;
  localparam logic       NRG_RST       = 1'b1;
  localparam logic       RSV_RST       = 1'b0;
  localparam logic       LH_RST        = 1'b0;
  localparam logic [2:0] MODE_AN_DEF   = 3'h7;
  localparam logic [4:0] ADDR_SEL0_DEF = 5'h01;
  localparam logic [4:0] ADDR_SEL1_DEF = 5'h02;
  // Timing
  localparam int unsigned CLK_HZ         = 25000000;
  localparam int unsigned MS_TICK_CYCLES = CLK_HZ / 1000;
  localparam int unsigned NRG_TIMEOUT_MS = 256;
  // Operating modes
  typedef enum logic [2:0] {
    MODE_10HD  = 3'b000,
    MODE_10FD  = 3'b001,
    MODE_100HD = 3'b010,
    MODE_100FD = 3'b011,
    MODE_AN_HD = 3'b100,
    MODE_RPTR  = 3'b101,
    MODE_PDOWN = 3'b110,
    MODE_ALL   = 3'b111
  } pamr_mode_type;
  // Latched configuration straps
  typedef struct packed {
    logic autoneg;
    logic speed;
    logic duplex;
    logic addr_sel;
  } pamr_straps_type;
  // Effects of the mode field; basic bits ordered 13,12,10,8, advert 8,7,6,5
  typedef struct packed {
    logic       autoneg_en;
    logic [3:0] basic_val;
    logic [3:0] basic_mask;
    logic [3:0] adv_val;
    logic [3:0] adv_mask;
    logic       crs_tx_rx;
    logic       repeater;
    logic       powerdown;
  } pamr_effect_type;
endpackage : pamr_pkg

// ---- hdl/pamr_sync3.sv ----
// Three-stage synchroniser that passes a change once stages two and three agree
`timescale 1ns/100ps
module pamr_sync3 #(
  parameter int unsigned W = 1
) (
  // Clock
  input  wire logic         i_sys_clk,
  // Asynchronous levels
  input  wire logic [W-1:0] i_async,
  // Filtered levels
  output logic      [W-1:0] o_level
);
  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;
  // Per-bit stage chain; only stage two reads stage one
  for (genvar b = 0; b < W; b++) begin : g_bit
    always_ff @(posedge i_sys_clk) begin
      s1_q[b] <= i_async[b];
      s2_q[b] <= s1_q[b];
      s3_q[b] <= s2_q[b];
      if (s2_q[b] == s3_q[b]) begin
        o_level[b] <= s3_q[b];
      end
    end
  end
endmodule : pamr_sync3

// ---- hdl/pamr_energy_timer.sv ----
// Line energy flag with a millisecond tick and a no-energy timeout
`timescale 1ns/100ps
module pamr_energy_timer
  import pamr_pkg::*;
#(
  parameter int unsigned P_TICK_CYCLES = MS_TICK_CYCLES,
  parameter int unsigned P_TIMEOUT_MS  = NRG_TIMEOUT_MS
) (
  // Clock and reset
  input  wire logic i_sys_clk,
  input  wire logic i_rst_n,
  // Synchronised energy detector level
  input  wire logic i_energy_seen,
  // Energy present flag
  output logic      o_energy_present
);
  logic [$clog2(P_TICK_CYCLES)-1:0] div_q;
  logic [$clog2(P_TIMEOUT_MS)-1:0]  ms_q;
  wire                              tick = (div_q == ($bits(div_q))'(P_TICK_CYCLES - 1));
  wire                              expire = tick && (ms_q == ($bits(ms_q))'(P_TIMEOUT_MS - 1));
  // Divider for the 1 ms enable pulse
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n || tick) begin
      div_q <= '0;
    end else begin
      div_q <= div_q + 1'b1;
    end
  end
  // Hardware reset sets the flag; only chip reset reaches here
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      o_energy_present <= NRG_RST;
      ms_q             <= '0;
    end else if (i_energy_seen) begin
      o_energy_present <= 1'b1;
      ms_q             <= '0;
    end else if (expire) begin
      o_energy_present <= 1'b0;
    end else if (tick && o_energy_present) begin
      ms_q <= ms_q + 1'b1;
    end
  end
  chk_energy_sets_flag: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    i_energy_seen |=> o_energy_present) else $error("energy seen but flag low");
  chk_energy_no_early_clear: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    $fell(o_energy_present) |-> $past(expire)) else $error("energy flag cleared before timeout");
endmodule : pamr_energy_timer

// ---- hdl/pamr_phy_mode_regs.sv ----
// PHY expansion, mode control/status and special-modes registers of one port
// What this block does
// - Fault bit latches on parallel-detect fault
// - Bit 3 shows partner next-page ability
// - Bit 2 shows local next-page ability
// - Bit 1 latches on new page received
// - Bit 0 partner negotiation able; 15:5 zero
// - Bit 13 enables energy-detect power-down
// - Energy flag clears after 256 ms silence
// - Energy flag survives soft reset, hardware sets
// - Loader rewrites special modes after reset, reload
// - Bits 7:5 hold writable mode select
// - Bits 4:0 management address, scrambler seed
// - Phy-only bits reset on qualified PHY reset
// - Negotiation strap set gives mode 111
// - Otherwise mode is 0, speed, duplex straps
// - Straps sampled as chip reset releases
// - Address default follows address-select strap
// - Codes 000-011 force speed and duplex
// - Code 100 advertises 100 half only
// - Code 101 is repeater, receive-only carrier
// - Code 110 powers down, touches nothing
// - Code 111 advertises every capability
`timescale 1ns/100ps
module pamr_phy_mode_regs
  import pamr_pkg::*;
#(
  parameter logic        P_LOCAL_NP_ABLE = 1'b0,
  parameter int unsigned P_TICK_CYCLES   = MS_TICK_CYCLES,
  parameter int unsigned P_TIMEOUT_MS    = NRG_TIMEOUT_MS
) (
  // Clock and chip reset
  input  wire logic                 i_sys_clk,
  input  wire logic                 i_rst_n,
  // Management register port
  input  wire logic [IDX_W-1:0]     i_reg_idx,
  input  wire logic                 i_reg_wr,
  input  wire logic                 i_reg_rd,
  input  wire logic [REG_W-1:0]     i_reg_wdata,
  output logic      [REG_W-1:0]     o_reg_rdata,
  output logic                      o_reg_rvalid,
  // Configuration loader
  input  wire logic                 i_loader_wr,
  input  wire logic [REG_W-1:0]     i_loader_data,
  // PHY resets
  input  wire logic                 i_chip_phy_rst,
  input  wire logic                 i_basic_rst_bit,
  // Negotiation status from the PHY core
  input  wire logic                 i_par_det_fault,
  input  wire logic                 i_page_rx,
  input  wire logic                 i_lp_np_able,
  input  wire logic                 i_lp_an_able,
  // Pins: straps and energy detector
  input  wire logic                 i_autoneg_strap,
  input  wire logic                 i_speed_strap,
  input  wire logic                 i_duplex_strap,
  input  wire logic                 i_addr_sel_strap,
  input  wire logic                 i_line_energy,
  // Mode effects and control
  output logic      [4:0]           o_mgmt_address,
  output logic                      o_edpd_en,
  output logic                      o_line_energy_present,
  output pamr_effect_type           o_effect
);
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_n);

  // Register state
  logic            rst_done_q;
  pamr_straps_type straps_q;
  logic            pd_fault_q;
  logic            page_rx_q;
  logic            edpd_q;
  logic            rsv0_q;
  logic [2:0]      mode_q;
  logic [4:0]      addr_q;
  logic            energy_present;

  // Synchronised pins
  logic [4:0]      pin_sync;
  pamr_straps_type straps_now;
  logic            energy_seen;

  pamr_sync3 #(
    .W (5)
  ) u_pin_sync (
    .i_sys_clk (i_sys_clk),
    .i_async   ({i_autoneg_strap, i_speed_strap, i_duplex_strap, i_addr_sel_strap, i_line_energy}),
    .o_level   (pin_sync)
  );

  assign straps_now  = pamr_straps_type'(pin_sync[4:1]);
  assign energy_seen = pin_sync[0];

  // Energy flag and its timeout
  pamr_energy_timer #(
    .P_TICK_CYCLES (P_TICK_CYCLES),
    .P_TIMEOUT_MS  (P_TIMEOUT_MS)
  ) u_energy (
    .i_sys_clk        (i_sys_clk),
    .i_rst_n          (i_rst_n),
    .i_energy_seen    (energy_seen),
    .o_energy_present (energy_present)
  );

  // Access decode
  wire sel_exp   = (i_reg_idx == IDX_AN_EXP);
  wire sel_mcs   = (i_reg_idx == IDX_MODE_CS);
  wire sel_spc   = (i_reg_idx == IDX_SPC_MODE);
  wire exp_rd    = rst_done_q && i_reg_rd && sel_exp;
  wire host_ok   = rst_done_q && i_reg_wr;
  wire mcs_wr    = host_ok && sel_mcs;
  wire spc_wr    = host_ok && sel_spc;
  wire soft_rst  = rst_done_q && i_chip_phy_rst;
  wire phy_reset_only_bits_rst  = soft_rst && i_basic_rst_bit;
  wire first_cyc = i_rst_n && !rst_done_q;

  // Defaults from the straps, live or latched
  wire [2:0] mode_def_now  = straps_now.autoneg ? MODE_AN_DEF
                                                : {1'b0, straps_now.speed, straps_now.duplex};
  wire [2:0] mode_def_held = straps_q.autoneg ? MODE_AN_DEF
                                              : {1'b0, straps_q.speed, straps_q.duplex};
  wire [4:0] addr_def_now  = straps_now.addr_sel ? ADDR_SEL1_DEF : ADDR_SEL0_DEF;

  // Read view of each register
  logic [REG_W-1:0] exp_view;
  logic [REG_W-1:0] mcs_view;
  logic [REG_W-1:0] spc_view;
  always_comb begin
    exp_view               = '0;
    exp_view[EXP_PDF_BIT]  = pd_fault_q;
    exp_view[EXP_LPNP_BIT] = i_lp_np_able;
    exp_view[EXP_LCNP_BIT] = P_LOCAL_NP_ABLE;
    exp_view[EXP_PGRX_BIT] = page_rx_q;
    exp_view[EXP_LPAN_BIT] = i_lp_an_able;
  end
  always_comb begin
    mcs_view               = '0;
    mcs_view[MCS_EDPD_BIT] = edpd_q;
    mcs_view[MCS_NRG_BIT]  = energy_present;
    mcs_view[MCS_RSV_BIT]  = rsv0_q;
  end
  always_comb begin
    spc_view                           = '0;
    spc_view[SM_MODE_MSB:SM_MODE_LSB]  = mode_q;
    spc_view[SM_ADDR_MSB:0]            = addr_q;
  end
  wire [REG_W-1:0] rd_mux = sel_exp ? exp_view :
                            sel_mcs ? mcs_view :
                            sel_spc ? spc_view : '0;

  // Strap capture on the first cycle after chip reset
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      rst_done_q <= 1'b0;
    end else if (first_cyc) begin
      rst_done_q <= 1'b1;
      straps_q   <= straps_now;
    end
  end

  // Latching-high bits; a new event wins over the read clear
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n || soft_rst) begin
      pd_fault_q <= LH_RST;
      page_rx_q  <= LH_RST;
    end else begin
      pd_fault_q <= i_par_det_fault || (pd_fault_q && !exp_rd);
      page_rx_q  <= i_page_rx || (page_rx_q && !exp_rd);
    end
  end

  // Mode control bits; energy flag is outside soft reset
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n || soft_rst) begin
      edpd_q <= EDPD_RST;
      rsv0_q <= RSV_RST;
    end else if (mcs_wr) begin
      edpd_q <= i_reg_wdata[MCS_EDPD_BIT];
      rsv0_q <= i_reg_wdata[MCS_RSV_BIT];
    end
  end

  // Special modes: strap defaults first, then loader, then phy-only reset, then host
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      mode_q <= MODE_AN_DEF;
      addr_q <= ADDR_SEL0_DEF;
    end else if (first_cyc) begin
      mode_q <= mode_def_now;
      addr_q <= addr_def_now;
    end else if (i_loader_wr) begin
      mode_q <= i_loader_data[SM_MODE_MSB:SM_MODE_LSB];
      addr_q <= i_loader_data[SM_ADDR_MSB:0];
    end else if (phy_reset_only_bits_rst) begin
      mode_q <= mode_def_held;
    end else if (spc_wr) begin
      mode_q <= i_reg_wdata[SM_MODE_MSB:SM_MODE_LSB];
      addr_q <= i_reg_wdata[SM_ADDR_MSB:0];
    end
  end

  // Effect decode of the mode field
  pamr_effect_type eff;
  always_comb begin
    eff = '0;
    case (pamr_mode_type'(mode_q))
      MODE_10HD: begin
        eff.basic_val  = 4'h0;
        eff.basic_mask = 4'hF;
        eff.crs_tx_rx  = 1'b1;
      end
      MODE_10FD: begin
        eff.basic_val  = 4'h1;
        eff.basic_mask = 4'hF;
      end
      MODE_100HD: begin
        eff.basic_val  = 4'h8;
        eff.basic_mask = 4'hF;
        eff.crs_tx_rx  = 1'b1;
      end
      MODE_100FD: begin
        eff.basic_val  = 4'h9;
        eff.basic_mask = 4'hF;
      end
      MODE_AN_HD: begin
        eff.autoneg_en = 1'b1;
        eff.basic_val  = 4'hC;
        eff.basic_mask = 4'hF;
        eff.adv_val    = 4'h4;
        eff.adv_mask   = 4'hF;
        eff.crs_tx_rx  = 1'b1;
      end
      MODE_RPTR: begin
        eff.autoneg_en = 1'b1;
        eff.basic_val  = 4'hC;
        eff.basic_mask = 4'hF;
        eff.adv_val    = 4'h4;
        eff.adv_mask   = 4'hF;
        eff.repeater   = 1'b1;
      end
      MODE_PDOWN: begin
        eff.powerdown = 1'b1;
      end
      MODE_ALL: begin
        eff.autoneg_en = 1'b1;
        eff.basic_val  = 4'h4;
        eff.basic_mask = 4'h6;
        eff.adv_val    = 4'hF;
        eff.adv_mask   = 4'hF;
        eff.crs_tx_rx  = 1'b1;
      end
      default: begin
        eff = '0;
      end
    endcase
  end

  // Registered outputs
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      o_reg_rdata           <= '0;
      o_reg_rvalid          <= 1'b0;
      o_mgmt_address        <= ADDR_SEL0_DEF;
      o_edpd_en             <= EDPD_RST;
      o_line_energy_present <= NRG_RST;
      o_effect              <= '0;
    end else begin
      o_reg_rvalid          <= rst_done_q && i_reg_rd;
      if (rst_done_q && i_reg_rd) begin
        o_reg_rdata <= rd_mux;
      end
      o_mgmt_address        <= addr_q;
      o_edpd_en             <= edpd_q;
      o_line_energy_present <= energy_present;
      o_effect              <= eff;
    end
  end

  // Checks
  chk_fault_latch_set: assert property (
    i_par_det_fault && !soft_rst |=> pd_fault_q) else $error("fault event not latched");
  chk_latch_holds_unread: assert property (
    (pd_fault_q && !exp_rd && !soft_rst |=> pd_fault_q) and
    (page_rx_q && !exp_rd && !soft_rst |=> page_rx_q))
    else $error("latched bit dropped without read");
  chk_page_latch_set: assert property (
    i_page_rx && !soft_rst |=> page_rx_q) else $error("page event not latched");
  chk_fault_clear_on_read: assert property (
    exp_rd && !i_par_det_fault && !soft_rst |=> !pd_fault_q) else $error("fault bit not cleared by read");
  chk_soft_rst_clears: assert property (
    soft_rst |=> !edpd_q && !rsv0_q && !pd_fault_q && !page_rx_q)
    else $error("soft reset left control bits set");
  chk_phy_reset_only_bits_keeps_addr: assert property (
    phy_reset_only_bits_rst && !i_loader_wr |=> addr_q == $past(addr_q)) else $error("phy reset changed the address");
  chk_host_mode_write: assert property (
    spc_wr && !i_loader_wr && !phy_reset_only_bits_rst |=> mode_q == $past(i_reg_wdata[7:5]))
    else $error("mode select not written");
  chk_host_addr_write: assert property (
    spc_wr && !i_loader_wr && !phy_reset_only_bits_rst |=> addr_q == $past(i_reg_wdata[4:0]))
    else $error("address not written");
  chk_strap_capture: assert property (
    $rose(rst_done_q) |-> straps_q == $past(straps_now))
    else $error("straps not captured at reset release");
  chk_addr_default: assert property (
    $rose(rst_done_q) |-> addr_q == (straps_q.addr_sel ? ADDR_SEL1_DEF : ADDR_SEL0_DEF))
    else $error("address default differs from strap");
  chk_page_clear_on_read: assert property (
    exp_rd && !i_page_rx |=> !page_rx_q) else $error("page bit not cleared by read");
  chk_exp_read_fields: assert property (
    exp_rd |=> o_reg_rvalid && o_reg_rdata[EXP_LPNP_BIT] == $past(i_lp_np_able)
      && o_reg_rdata[EXP_LCNP_BIT] == P_LOCAL_NP_ABLE) else $error("next page bits wrong");
  chk_exp_reserved_zero: assert property (
    exp_rd |=> o_reg_rdata[15:5] == 11'h000 && o_reg_rdata[0] == $past(i_lp_an_able))
    else $error("expansion reserved or ability bit wrong");
  chk_edpd_write: assert property (
    mcs_wr && !soft_rst |=> ##1 o_edpd_en == $past(i_reg_wdata[MCS_EDPD_BIT], 2))
    else $error("power-down enable not written");
  chk_loader_rewrite: assert property (
    i_loader_wr && rst_done_q |=> mode_q == $past(i_loader_data[7:5]) && addr_q == $past(i_loader_data[4:0]))
    else $error("loader write lost");
  chk_phy_reset_only_bits_default: assert property (
    phy_reset_only_bits_rst && !i_loader_wr |=> mode_q == $past(mode_def_held)) else $error("mode not reset to default");
  chk_strap_default: assert property (
    $rose(rst_done_q) |-> mode_q == (straps_q.autoneg ? 3'h7 : {1'b0, straps_q.speed, straps_q.duplex}))
    else $error("mode default differs from straps");
  chk_energy_soft_keep: assert property (
    soft_rst && energy_present |=> energy_present) else $error("soft reset cleared energy flag");
  chk_all_capable: assert property (
    mode_q == 3'h7 ##1 mode_q == 3'h7 |-> o_effect.adv_val == 4'hF && o_effect.autoneg_en)
    else $error("all-capable mode effect wrong");

  // Mode effect checks, one cycle after the mode field
  chk_forced_modes: assert property (
    !mode_q[2] |=> !o_effect.autoneg_en && o_effect.basic_mask == 4'hF && o_effect.crs_tx_rx == !$past(mode_q[0])
      && o_effect.basic_val == {$past(mode_q[1]), 2'b00, $past(mode_q[0])})
    else $error("forced mode effect wrong");
  chk_adv_half_only: assert property (
    mode_q == 3'h4 |=> o_effect.autoneg_en && o_effect.basic_val == 4'hC && o_effect.adv_val == 4'h4
      && o_effect.crs_tx_rx) else $error("half duplex advert effect wrong");
  chk_repeater_crs: assert property (
    mode_q == 3'h5 |=> o_effect.repeater && o_effect.autoneg_en && o_effect.adv_val == 4'h4
      && !o_effect.crs_tx_rx) else $error("repeater effect wrong");
  chk_powerdown_only: assert property (
    mode_q == 3'h6 |=> o_effect.powerdown && o_effect.basic_mask == 4'h0 && o_effect.adv_mask == 4'h0)
    else $error("power-down mode touched other bits");
  chk_all_basic_bits: assert property (
    mode_q == 3'h7 |=> o_effect.basic_val == 4'h4 && o_effect.basic_mask == 4'h6)
    else $error("all-capable basic bits wrong");
endmodule : pamr_phy_mode_regs

// ---- tb/pamr_host_model.sv ----
// Management host model that drives the register port of the PHY mode bank
`timescale 1ns/100ps
module pamr_host_model
  import pamr_pkg::*;
(
  // Clock
  input  wire logic             i_sys_clk,
  // Requests toward the block
  output logic      [IDX_W-1:0] o_reg_idx,
  output logic                  o_reg_wr,
  output logic                  o_reg_rd,
  output logic      [REG_W-1:0] o_reg_wdata,
  // Answers from the block
  input  wire logic [REG_W-1:0] i_reg_rdata,
  input  wire logic             i_reg_rvalid
);
  // Idle bus at time zero
  initial begin
    o_reg_idx   = 5'h00;
    o_reg_wr    = 1'b0;
    o_reg_rd    = 1'b0;
    o_reg_wdata = 16'h0000;
  end

  // One write pulse; released lines show the inverse so stale values never match
  task automatic reg_write(input logic [IDX_W-1:0] idx, input logic [REG_W-1:0] data);
    @(negedge i_sys_clk);
    o_reg_idx   = idx;
    o_reg_wdata = data;
    o_reg_wr    = 1'b1;
    @(negedge i_sys_clk);
    o_reg_wr    = 1'b0;
    o_reg_wdata = ~data;
    o_reg_idx   = ~idx;
  endtask : reg_write

  // One read pulse, then a bounded wait for the answer; a lost answer reads unknown
  task automatic reg_read(input logic [IDX_W-1:0] idx, output logic [REG_W-1:0] data);
    int n;
    n = 0;
    @(negedge i_sys_clk);
    o_reg_idx = idx;
    o_reg_rd  = 1'b1;
    @(negedge i_sys_clk);
    o_reg_rd  = 1'b0;
    o_reg_idx = ~idx;
    while (i_reg_rvalid !== 1'b1 && n < 4) begin
      @(negedge i_sys_clk);
      n++;
    end
    data = (i_reg_rvalid === 1'b1) ? i_reg_rdata : 16'hXXXX;
  endtask : reg_read
endmodule : pamr_host_model

// ---- tb/tb_pamr_phy_mode_regs.sv ----
// Self-checking testbench for the PHY mode register bank
`timescale 1ns/100ps
module tb_pamr_phy_mode_regs;
  import pamr_pkg::*;
  logic              clk;
  logic              rst_n;
  logic [IDX_W-1:0]  idx;
  logic              wr;
  logic              rd;
  logic [REG_W-1:0]  wdata;
  logic [REG_W-1:0]  rdata;
  logic              rvalid;
  logic              ld_wr;
  logic [REG_W-1:0]  ld_data;
  logic              phy_rst;
  logic              basic_rst;
  logic              fault;
  logic              page;
  logic              lp_np;
  logic              lp_an;
  logic [3:0]        straps;
  logic              line;
  logic [4:0]        addr;
  logic              edpd;
  logic              nrg;
  pamr_effect_type   eff;
  logic [39:0]       ee;
  int                num_errors;
  int                checks;

  pamr_phy_mode_regs #(.P_LOCAL_NP_ABLE(1'b1), .P_TICK_CYCLES(10), .P_TIMEOUT_MS(4)) u_pamr_phy_mode_regs (
    .i_sys_clk(clk), .i_rst_n(rst_n), .i_reg_idx(idx), .i_reg_wr(wr), .i_reg_rd(rd),
    .i_reg_wdata(wdata), .o_reg_rdata(rdata), .o_reg_rvalid(rvalid), .i_loader_wr(ld_wr),
    .i_loader_data(ld_data), .i_chip_phy_rst(phy_rst), .i_basic_rst_bit(basic_rst),
    .i_par_det_fault(fault), .i_page_rx(page), .i_lp_np_able(lp_np), .i_lp_an_able(lp_an),
    .i_autoneg_strap(straps[3]), .i_speed_strap(straps[2]), .i_duplex_strap(straps[1]),
    .i_addr_sel_strap(straps[0]), .i_line_energy(line), .o_mgmt_address(addr),
    .o_edpd_en(edpd), .o_line_energy_present(nrg), .o_effect(eff));

  pamr_host_model u_pamr_host_model (
    .i_sys_clk(clk), .o_reg_idx(idx), .o_reg_wr(wr), .o_reg_rd(rd),
    .o_reg_wdata(wdata), .i_reg_rdata(rdata), .i_reg_rvalid(rvalid));

  // 25 MHz clock
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // Compare and count
  task automatic check(input string name, input logic [19:0] seen, input logic [19:0] exp);
    checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error: %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  // Read one register and compare
  task automatic rd_chk(input logic [4:0] i, input logic [15:0] exp);
    logic [15:0] v;
    u_pamr_host_model.reg_read(i, v);
    check($sformatf("register %h", i), {4'h0, v}, {4'h0, exp});
  endtask : rd_chk

  // Chip reset for 16 cycles with straps {autoneg, speed, duplex, addr_sel}
  task automatic do_reset(input logic [3:0] s);
    @(negedge clk);
    rst_n  = 1'b0;
    straps = s;
    repeat (16) @(negedge clk);
    check("energy flag in reset", {19'h0, nrg}, 20'h00001);
    rst_n = 1'b1;
    repeat (2) @(negedge clk);
  endtask : do_reset

  // Effect expected for a mode, upper half value, lower half care mask
  function automatic logic [39:0] eff_exp(input logic [2:0] m);
    logic [3:0] bv, bm, av, am;
    logic       dc;
    dc = (m == 3'b110);
    bv = m[2] ? 4'hC : {m[1], 2'b00, m[0]};
    bm = dc ? 4'h0 : ((m == 3'b111) ? 4'h6 : 4'hF);
    if (m == 3'b111) bv = 4'h4;
    av = (m == 3'b111) ? 4'hF : 4'h4;
    am = (m[2] & ~dc) ? 4'hF : 4'h0;
    return {m[2] & ~dc, bv, bm, av, am, ~m[0] | (m == 3'b111), m == 3'b101, dc,
            ~dc, bm, 4'hF, am, 4'hF, ~dc, 2'b11};
  endfunction : eff_exp

  // Pulse one input for one cycle
  task automatic pulse(ref logic s);
    @(negedge clk);
    s = 1'b1;
    @(negedge clk);
    s = 1'b0;
  endtask : pulse

  // Verdict
  task automatic test_done;
    $display("Checks %0d errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : test_done

  // Watchdog well beyond the expected run of about 250 cycles
  initial begin
    repeat (6000) @(posedge clk);
    num_errors++;
    test_done();
  end

  // Main sequence
  initial begin
    num_errors = 0;
    checks = 0;
    {rst_n, ld_wr, phy_rst, basic_rst, fault, page, lp_np, lp_an} = 8'h00;
    ld_data = 16'h0000;
    straps = 4'b1000;
    line = 1'b1;
    do_reset(4'b1000);
    rd_chk(IDX_SPC_MODE, 16'h00E1);
    rd_chk(IDX_MODE_CS, 16'h0002);
    u_pamr_host_model.reg_write(5'h1F, 16'hFFFF);
    rd_chk(5'h1F, 16'h0000);
    rd_chk(IDX_AN_EXP, 16'h0004);
    u_pamr_host_model.reg_write(IDX_AN_EXP, 16'hFFFF);
    lp_np = 1'b1;
    lp_an = 1'b1;
    rd_chk(IDX_AN_EXP, 16'h000D);
    pulse(fault);
    rd_chk(IDX_AN_EXP, 16'h001D);
    rd_chk(IDX_AN_EXP, 16'h000D);
    pulse(page);
    rd_chk(IDX_AN_EXP, 16'h000F);
    rd_chk(IDX_AN_EXP, 16'h000D);
    fault = 1'b1;
    rd_chk(IDX_AN_EXP, 16'h001D);
    rd_chk(IDX_AN_EXP, 16'h001D);
    fault = 1'b0;
    rd_chk(IDX_AN_EXP, 16'h001D);
    lp_np = 1'b0;
    lp_an = 1'b0;
    rd_chk(IDX_AN_EXP, 16'h0004);
    u_pamr_host_model.reg_write(IDX_MODE_CS, 16'hFFFF);
    repeat (2) @(negedge clk);
    check("edpd enable", {19'h0, edpd}, 20'h00001);
    rd_chk(IDX_MODE_CS, 16'h2003);
    u_pamr_host_model.reg_write(IDX_SPC_MODE, 16'h0043);
    pulse(phy_rst);
    repeat (2) @(negedge clk);
    rd_chk(IDX_SPC_MODE, 16'h0043);
    rd_chk(IDX_MODE_CS, 16'h0002);
    check("edpd enable", {19'h0, edpd}, 20'h00000);
    basic_rst = 1'b1;
    pulse(phy_rst);
    basic_rst = 1'b0;
    rd_chk(IDX_SPC_MODE, 16'h00E3);
    @(negedge clk);
    ld_data = 16'h00A5;
    ld_wr = 1'b1;
    @(negedge clk);
    ld_wr = 1'b0;
    ld_data = 16'hFF5A;
    repeat (2) @(negedge clk);
    check("address", {15'h0, addr}, 20'h00005);
    rd_chk(IDX_SPC_MODE, 16'h00A5);
    for (int m = 0; m < 8; m++) begin
      ee = eff_exp(m[2:0]);
      u_pamr_host_model.reg_write(IDX_SPC_MODE, {8'h00, m[2:0], 5'h04});
      repeat (2) @(negedge clk);
      check("effect", eff & ee[19:0], ee[39:20] & ee[19:0]);
      check("address", {15'h0, addr}, 20'h00004);
      rd_chk(IDX_SPC_MODE, {8'h00, m[2:0], 5'h04});
    end
    line = 1'b0;
    repeat (25) @(negedge clk);
    check("energy flag", {19'h0, nrg}, 20'h00001);
    repeat (35) @(negedge clk);
    check("energy flag", {19'h0, nrg}, 20'h00000);
    rd_chk(IDX_MODE_CS, 16'h0000);
    basic_rst = 1'b1;
    pulse(phy_rst);
    basic_rst = 1'b0;
    repeat (2) @(negedge clk);
    check("energy flag", {19'h0, nrg}, 20'h00000);
    do_reset(4'b0101);
    rd_chk(IDX_SPC_MODE, 16'h0042);
    line = 1'b1;
    repeat (10) @(negedge clk);
    check("energy flag", {19'h0, nrg}, 20'h00001);
    do_reset(4'b0010);
    rd_chk(IDX_SPC_MODE, 16'h0021);
    test_done();
  end
endmodule : tb_pamr_phy_mode_regs
